// ### hdl/dmc_context_control.sv
// Purpose: Per-context go/busy/rescan/halted control, command pointer,
//          descriptor fetch arbitration and asynchronous receive routing.
// Assumes: Scheduling slots, faults and fetch answers are same-clock.
// Notes: Operation
//
// Implementation choices: strobed register access and the placing of the registers.
`default_nettype none

module dmc_context_control #(
  parameter int NUM_CTX = 4,
  parameter int AR_REQ_CTX = 2,
  parameter logic [3:0] MAX_COUNT = 4'h8,
  localparam int IDX_W = $clog2(NUM_CTX)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [NUM_CTX-1:0] sched_slot,
  input wire logic [NUM_CTX-1:0] ctx_fault,
  input wire logic [4:0] fault_code,
  output logic fetch_req,
  output dmc_pkg::dmc_ptr_type fetch_ptr,
  output logic [IDX_W-1:0] fetch_ctx,
  input wire logic fetch_ack,
  input wire dmc_pkg::dmc_ptr_type fetch_ans,
  input wire logic fetch_err,
  output logic [NUM_CTX-1:0] ctx_done_evt,
  output logic [NUM_CTX-1:0] ctx_halt_evt,
  output logic fatal_error_event,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire dmc_pkg::dmc_rx_type rx_pkt,
  input wire logic selfid_phase,
  input wire logic resp_space,
  input wire logic req_fifo_full,
  output logic phys_valid,
  input wire logic phys_ready,
  output logic [31:0] phys_data,
  output logic [31:0] rx_out_data,
  output logic selfid_wr,
  output logic resp_wr,
  output logic req_wr,
  output logic ack_busy,
  output logic link_fail,
  input wire logic drain_valid,
  output logic drain_ready,
  input wire logic ctx_ready,
  output logic req_deliver
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  dmc_pkg::dmc_ctl_type ctl_reg [NUM_CTX];
  dmc_pkg::dmc_ctl_type ctl_next [NUM_CTX];
  dmc_pkg::dmc_ptr_type ptr_reg [NUM_CTX];
  dmc_pkg::dmc_ptr_type ptr_next [NUM_CTX];
  dmc_pkg::dmc_state_type st_reg [NUM_CTX];
  dmc_pkg::dmc_state_type st_next [NUM_CTX];
  logic [NUM_CTX-1:0] done_reg, done_next;
  logic [NUM_CTX-1:0] halt_reg, halt_next;
  logic [NUM_CTX-1:0] ctx_req;
  logic [NUM_CTX-1:0] ctx_ack;
  logic own_reg, own_next;
  logic [IDX_W-1:0] idx_reg, idx_next;
  dmc_pkg::dmc_ptr_type fptr_reg, fptr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic cfg_reg, cfg_next;
  logic [7:0] resp_cnt_reg, resp_cnt_next;
  logic [7:0] req_cnt_reg, req_cnt_next;
  logic resp_drop;
  logic drain_drop;

  function automatic logic count_ok(input logic [3:0] cnt);
    count_ok = (cnt >= dmc_pkg::CNT_MIN) && (cnt <= MAX_COUNT);
  endfunction : count_ok

  function automatic logic [31:0] ctl_word(input dmc_pkg::dmc_ctl_type c);
    logic [31:0] w;
    w = 32'h0;
    w[dmc_pkg::CTL_GO_BIT] = c.go;
    w[dmc_pkg::CTL_RESCAN_BIT] = c.rescan;
    w[dmc_pkg::CTL_HALTED_BIT] = c.halted;
    w[dmc_pkg::CTL_BUSY_BIT] = c.busy;
    w[dmc_pkg::CODE_W-1:0] = c.code;
    ctl_word = w;
  endfunction : ctl_word

  // ****************************************************************
  // Context control
  // ****************************************************************
  for (genvar i = 0; i < NUM_CTX; i++) begin : g_ctx
    localparam logic [7:0] A_CTL =
      8'(dmc_pkg::REG_CTL_BASE + i * dmc_pkg::CTX_STRIDE);
    localparam logic [7:0] A_PTR =
      8'(dmc_pkg::REG_PTR_BASE + i * dmc_pkg::CTX_STRIDE);

    assign ctx_req[i] = (st_reg[i] == dmc_pkg::CS_FETCH) ||
      (st_reg[i] == dmc_pkg::CS_REREAD);
    assign ctx_ack[i] = fetch_ack && own_reg &&
      (idx_reg == IDX_W'(i));

    always_comb begin
      logic wsel;
      logic halt;
      logic stop;
      logic [4:0] hcode;
      wsel = reg_wr && (reg_addr == A_CTL);
      halt = 1'b0;
      stop = 1'b0;
      hcode = dmc_pkg::EVT_UNKNOWN;
      ctl_next[i] = ctl_reg[i];
      ptr_next[i] = ptr_reg[i];
      st_next[i] = st_reg[i];
      // Only go and rescan take software writes.
      if (wsel) begin
        ctl_next[i].go = reg_wdata[dmc_pkg::CTL_GO_BIT];
        if (reg_wdata[dmc_pkg::CTL_RESCAN_BIT]) begin
          ctl_next[i].rescan = 1'b1;
        end
      end
      // Rescan is meaningless while go is clear.
      if (!ctl_next[i].go) begin
        ctl_next[i].rescan = 1'b0;
      end
      // Pointer writes outside the idle window are ignored.
      if (reg_wr && reg_addr == A_PTR && !ctl_reg[i].go &&
          !ctl_reg[i].busy) begin
        ptr_next[i] = reg_wdata[31:0];
      end
      case (st_reg[i])
        dmc_pkg::CS_IDLE: begin
          if (ctl_next[i].go && !ctl_reg[i].halted &&
              (!ctl_reg[i].go || ctl_next[i].rescan)) begin
            ctl_next[i].busy = 1'b1;
            if (!ctl_reg[i].go && !count_ok(ptr_next[i].count)) begin
              halt = 1'b1;
            end else begin
              st_next[i] = dmc_pkg::CS_WAIT;
            end
          end
        end
        dmc_pkg::CS_WAIT: begin
          if (!ctl_next[i].go) begin
            stop = 1'b1;
          end else if (sched_slot[i]) begin
            ctl_next[i].rescan = 1'b0;
            st_next[i] = dmc_pkg::CS_FETCH;
          end
        end
        dmc_pkg::CS_FETCH, dmc_pkg::CS_REREAD: begin
          if (ctx_ack[i]) begin
            if (fetch_err) begin
              halt = 1'b1;
            end else if (!ctl_next[i].go) begin
              stop = 1'b1;
            end else if (fetch_ans.count == '0) begin
              if (st_reg[i] == dmc_pkg::CS_FETCH) begin
                ctl_next[i].rescan = 1'b0;
                st_next[i] = dmc_pkg::CS_REREAD;
              end else begin
                stop = 1'b1;
              end
            end else if (!count_ok(fetch_ans.count)) begin
              halt = 1'b1;
            end else begin
              ptr_next[i] = fetch_ans;
              st_next[i] = dmc_pkg::CS_WAIT;
            end
          end
        end
        default: begin
          st_next[i] = dmc_pkg::CS_IDLE;
        end
      endcase
      if (ctx_fault[i] && ctl_reg[i].busy) begin
        halt = 1'b1;
        hcode = fault_code;
      end
      if (stop) begin
        ctl_next[i].busy = 1'b0;
        st_next[i] = dmc_pkg::CS_IDLE;
      end
      // The pointer keeps the failing block; go stays as it is.
      if (halt) begin
        ctl_next[i].halted = 1'b1;
        ctl_next[i].busy = 1'b0;
        ctl_next[i].code = hcode;
        st_next[i] = dmc_pkg::CS_IDLE;
      end
      if (!ctl_next[i].go) begin
        ctl_next[i].halted = 1'b0;
      end
      halt_next[i] = halt;
      done_next[i] = ctl_reg[i].busy && !ctl_next[i].busy &&
        !ctl_next[i].go && !halt;
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ctl_reg[i] <= '{go: 1'b0, rescan: 1'b0, halted: 1'b0,
          busy: 1'b0, code: dmc_pkg::CODE_RST};
        ptr_reg[i] <= '0;
        st_reg[i] <= dmc_pkg::CS_IDLE;
      end else begin
        ctl_reg[i] <= ctl_next[i];
        ptr_reg[i] <= ptr_next[i];
        st_reg[i] <= st_next[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= '0;
      halt_reg <= '0;
    end else begin
      done_reg <= done_next;
      halt_reg <= halt_next;
    end
  end

  assign ctx_done_evt = done_reg;
  assign ctx_halt_evt = halt_reg;
  assign fatal_error_event = |halt_reg;

  // ****************************************************************
  // Descriptor fetch arbitration
  // ****************************************************************
  // One fetch owns the port until its answer; lowest index wins.
  always_comb begin
    own_next = own_reg;
    idx_next = idx_reg;
    fptr_next = fptr_reg;
    if (own_reg) begin
      if (fetch_ack) begin
        own_next = 1'b0;
      end
    end else begin
      for (int k = NUM_CTX - 1; k >= 0; k--) begin
        if (ctx_req[k]) begin
          own_next = 1'b1;
          idx_next = IDX_W'(k);
          fptr_next = ptr_reg[k];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      own_reg <= 1'b0;
      idx_reg <= '0;
      fptr_reg <= '0;
    end else begin
      own_reg <= own_next;
      idx_reg <= idx_next;
      fptr_reg <= fptr_next;
    end
  end

  assign fetch_req = own_reg;
  assign fetch_ptr = fptr_reg;
  assign fetch_ctx = idx_reg;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  always_comb begin
    logic [IDX_W-1:0] sel;
    sel = reg_addr[IDX_W+2:3];
    rdata_next = 32'h0;
    cfg_next = cfg_reg;
    resp_cnt_next = resp_cnt_reg;
    req_cnt_next = req_cnt_reg;
    if (reg_wr && reg_addr == dmc_pkg::REG_RX_CFG) begin
      cfg_next = reg_wdata[dmc_pkg::CFG_SELFID_BIT];
    end
    if (reg_wr && reg_addr == dmc_pkg::REG_RX_STAT) begin
      resp_cnt_next = 8'h0;
      req_cnt_next = 8'h0;
    end
    // Drop counts saturate; a new drop outranks the clear.
    if (resp_drop && resp_cnt_next != 8'hFF) begin
      resp_cnt_next = resp_cnt_next + 8'h1;
    end
    if (drain_drop && req_cnt_next != 8'hFF) begin
      req_cnt_next = req_cnt_next + 8'h1;
    end
    if (reg_rd) begin
      if (reg_addr < 8'(NUM_CTX * 8)) begin
        if (reg_addr[2]) begin
          rdata_next = ptr_reg[sel];
        end else begin
          rdata_next = ctl_word(ctl_reg[sel]);
        end
      end else if (reg_addr == dmc_pkg::REG_RX_CFG) begin
        rdata_next[dmc_pkg::CFG_SELFID_BIT] = cfg_reg;
      end else if (reg_addr == dmc_pkg::REG_RX_STAT) begin
        rdata_next[dmc_pkg::STAT_FAIL_BIT] = link_fail;
        rdata_next[dmc_pkg::STAT_RESP_LSB +: 8] = resp_cnt_reg;
        rdata_next[dmc_pkg::STAT_REQ_LSB +: 8] = req_cnt_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0;
      cfg_reg <= dmc_pkg::CFG_SELFID_RST;
      resp_cnt_reg <= 8'h0;
      req_cnt_reg <= 8'h0;
    end else begin
      rdata_reg <= rdata_next;
      cfg_reg <= cfg_next;
      resp_cnt_reg <= resp_cnt_next;
      req_cnt_reg <= req_cnt_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ****************************************************************
  // Asynchronous receive routing
  // ****************************************************************
  dmc_rx_router u_router (
    .clk(clk),
    .rst_n(rst_n),
    .rx_valid(rx_valid),
    .rx_ready(rx_ready),
    .rx_pkt(rx_pkt),
    .selfid_phase(selfid_phase),
    .selfid_en(cfg_reg),
    .resp_space(resp_space),
    .req_fifo_full(req_fifo_full),
    .req_fail_set(halt_reg[AR_REQ_CTX]),
    .req_halted(ctl_reg[AR_REQ_CTX].halted),
    .phys_valid(phys_valid),
    .phys_ready(phys_ready),
    .phys_data(phys_data),
    .out_data(rx_out_data),
    .selfid_wr(selfid_wr),
    .resp_wr(resp_wr),
    .req_wr(req_wr),
    .ack_busy(ack_busy),
    .resp_drop(resp_drop),
    .link_fail(link_fail),
    .drain_valid(drain_valid),
    .drain_ready(drain_ready),
    .ctx_ready(ctx_ready),
    .req_deliver(req_deliver),
    .drain_drop(drain_drop)
  );

endmodule : dmc_context_control

`default_nettype wire

// ### hdl/dmc_pkg.sv
// Purpose: Shared constants and types for the DMA context control block.
// Assumes: One 125 MHz clock; register bus with byte addresses.
// Notes: Register offsets, field bit positions and the code and Self-ID reset values live here.
`default_nettype none

package dmc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] REG_CTL_BASE = 8'h00;
  localparam logic [7:0] REG_PTR_BASE = 8'h04;
  localparam logic [7:0] CTX_STRIDE = 8'h08;
  localparam logic [7:0] REG_RX_CFG = 8'h40;
  localparam logic [7:0] REG_RX_STAT = 8'h44;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int CTL_GO_BIT = 15;
  localparam int CTL_RESCAN_BIT = 12;
  localparam int CTL_HALTED_BIT = 11;
  localparam int CTL_BUSY_BIT = 10;
  localparam int CODE_W = 5;
  localparam int CNT_W = 4;
  localparam int ADDR_W = 28;
  localparam int CFG_SELFID_BIT = 0;
  localparam int STAT_FAIL_BIT = 0;
  localparam int STAT_RESP_LSB = 8;
  localparam int STAT_REQ_LSB = 16;
  localparam int DROP_W = 8;

  // ****************************************************************
  // Codes and reset values
  // ****************************************************************
  localparam logic [4:0] EVT_UNKNOWN = 5'h0E;
  localparam logic [4:0] CODE_RST = 5'h00;
  localparam logic [3:0] CNT_MIN = 4'h1;
  localparam logic CFG_SELFID_RST = 1'b1;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [CNT_W-1:0] count;
  } dmc_ptr_type;

  typedef struct packed {
    logic go;
    logic rescan;
    logic halted;
    logic busy;
    logic [CODE_W-1:0] code;
  } dmc_ctl_type;

  typedef enum logic [1:0] {
    PKT_PHYS,
    PKT_SELFID_FMT,
    PKT_RESPONSE,
    PKT_REQUEST
  } dmc_kind_type;

  typedef struct packed {
    dmc_kind_type kind;
    logic [31:0] data;
  } dmc_rx_type;

  typedef enum logic [1:0] {
    CS_IDLE,
    CS_WAIT,
    CS_FETCH,
    CS_REREAD
  } dmc_state_type;

endpackage : dmc_pkg

`default_nettype wire

// ### hdl/dmc_rx_router.sv
// Purpose: Routes received packets to physical, Self-ID, response and
//          request paths, busies requests and drains a halted context.
// Assumes: All inputs come from logic on the same clock.
// Notes: Only a physical packet meeting a full physical slot stalls.
`default_nettype none

module dmc_rx_router (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire dmc_pkg::dmc_rx_type rx_pkt,
  input wire logic selfid_phase,
  input wire logic selfid_en,
  input wire logic resp_space,
  input wire logic req_fifo_full,
  input wire logic req_fail_set,
  input wire logic req_halted,
  output logic phys_valid,
  input wire logic phys_ready,
  output logic [31:0] phys_data,
  output logic [31:0] out_data,
  output logic selfid_wr,
  output logic resp_wr,
  output logic req_wr,
  output logic ack_busy,
  output logic resp_drop,
  output logic link_fail,
  input wire logic drain_valid,
  output logic drain_ready,
  input wire logic ctx_ready,
  output logic req_deliver,
  output logic drain_drop
);

  logic take;
  logic is_req;
  logic phys_reg, phys_next;
  logic [31:0] pdata_reg, pdata_next;
  logic [31:0] data_reg, data_next;
  logic [4:0] strb_reg, strb_next;
  logic fail_reg, fail_next;

  assign rx_ready =
    !(phys_reg && rx_pkt.kind == dmc_pkg::PKT_PHYS);
  assign take = rx_valid && rx_ready;
  assign is_req = take && (rx_pkt.kind == dmc_pkg::PKT_REQUEST ||
    (rx_pkt.kind == dmc_pkg::PKT_SELFID_FMT && !selfid_phase));

  always_comb begin
    phys_next = phys_reg && !phys_ready;
    pdata_next = pdata_reg;
    if (take && rx_pkt.kind == dmc_pkg::PKT_PHYS) begin
      phys_next = 1'b1;
      pdata_next = rx_pkt.data;
    end
    data_next = take ? rx_pkt.data : data_reg;
    strb_next[0] = take && rx_pkt.kind == dmc_pkg::PKT_SELFID_FMT &&
      selfid_phase && selfid_en;
    strb_next[1] = take && rx_pkt.kind == dmc_pkg::PKT_RESPONSE &&
      resp_space;
    strb_next[2] = take && rx_pkt.kind == dmc_pkg::PKT_RESPONSE &&
      !resp_space;
    strb_next[3] = is_req && !(req_fifo_full || fail_reg);
    strb_next[4] = is_req && (req_fifo_full || fail_reg);
    fail_next = req_fail_set || (fail_reg && req_halted);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phys_reg <= 1'b0;
      pdata_reg <= 32'h0;
      data_reg <= 32'h0;
      strb_reg <= 5'h0;
      fail_reg <= 1'b0;
    end else begin
      phys_reg <= phys_next;
      pdata_reg <= pdata_next;
      data_reg <= data_next;
      strb_reg <= strb_next;
      fail_reg <= fail_next;
    end
  end

  assign phys_valid = phys_reg;
  assign phys_data = pdata_reg;
  assign out_data = data_reg;
  assign selfid_wr = strb_reg[0];
  assign resp_wr = strb_reg[1];
  assign resp_drop = strb_reg[2];
  assign req_wr = strb_reg[3];
  assign ack_busy = strb_reg[4];
  assign link_fail = fail_reg;

  // A halted request context still empties the FIFO; each dropped entry raises drain_drop.
  assign drain_ready = req_halted || ctx_ready;
  assign req_deliver = drain_valid && !req_halted;
  assign drain_drop = drain_valid && req_halted;

endmodule : dmc_rx_router

`default_nettype wire

// ### test/dmc_context_control_sva.sv
// Purpose: Port-level assertions for the DMA context control block.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound into every instance of the top module.
`default_nettype none

module dmc_context_control_sva #(
  parameter int NUM_CTX = 4,
  parameter int AR_REQ_CTX = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fetch_req,
  input wire dmc_pkg::dmc_ptr_type fetch_ptr,
  input wire logic fetch_ack,
  input wire logic [NUM_CTX-1:0] ctx_done_evt,
  input wire logic [NUM_CTX-1:0] ctx_halt_evt,
  input wire logic fatal_error_event,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire dmc_pkg::dmc_rx_type rx_pkt,
  input wire logic selfid_phase,
  input wire logic resp_space,
  input wire logic req_fifo_full,
  input wire logic phys_valid,
  input wire logic selfid_wr,
  input wire logic resp_wr,
  input wire logic req_wr,
  input wire logic ack_busy,
  input wire logic link_fail,
  input wire logic drain_valid,
  input wire logic req_deliver
);
  logic acc;
  assign acc = rx_valid && rx_ready;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  fatal_from_halt_a: assert property ((|ctx_halt_evt) |->
    fatal_error_event) else $error("halt without fatal event");
  fatal_cause_a: assert property (fatal_error_event |->
    (|ctx_halt_evt)) else $error("fatal event without halt");
  halt_no_done_a: assert property ((ctx_halt_evt & ctx_done_evt)
    == '0) else $error("completion beside halt");
  fetch_hold_a: assert property (fetch_req && !fetch_ack |=>
    fetch_req && $stable(fetch_ptr)) else $error("fetch request dropped");
  req_busied_a: assert property (acc &&
    rx_pkt.kind == dmc_pkg::PKT_REQUEST
    && (req_fifo_full || link_fail) |=> ack_busy && !req_wr)
    else $error("request not busied");
  resp_route_a: assert property (acc &&
    rx_pkt.kind == dmc_pkg::PKT_RESPONSE |=> resp_wr == $past(resp_space))
    else $error("response misrouted");
  selfid_phase_a: assert property (acc && !selfid_phase &&
    rx_pkt.kind == dmc_pkg::PKT_SELFID_FMT |=> !selfid_wr)
    else $error("self-id taken outside phase");
  phys_stall_a: assert property (!rx_ready |-> phys_valid)
    else $error("receive stalled without physical work");
  deliver_gate_a: assert property (req_deliver |-> drain_valid)
    else $error("delivery without drain data");
  link_fail_set_a: assert property (ctx_halt_evt[AR_REQ_CTX] |=>
    link_fail) else $error("link side not failed");
  link_fail_cause_a: assert property ($rose(link_fail) |->
    $past(ctx_halt_evt[AR_REQ_CTX])) else $error("link failed without halt");
  halt_seen_c: cover property (fatal_error_event);
  busied_c: cover property (ack_busy);
  fetch_done_c: cover property (fetch_req && fetch_ack);
endmodule : dmc_context_control_sva

bind dmc_context_control dmc_context_control_sva #(
  .NUM_CTX(NUM_CTX), .AR_REQ_CTX(AR_REQ_CTX)
) i_dmc_context_control_sva (
  .clk, .rst_n, .fetch_req, .fetch_ptr, .fetch_ack, .ctx_done_evt,
  .ctx_halt_evt, .fatal_error_event, .rx_valid, .rx_ready, .rx_pkt,
  .selfid_phase, .resp_space, .req_fifo_full, .phys_valid, .selfid_wr,
  .resp_wr, .req_wr, .ack_busy, .link_fail, .drain_valid, .req_deliver
);

`default_nettype wire

// ### test/dmc_mem_model.sv
// Purpose: Memory side answering descriptor fetches.
// Assumes: Answer and delay are set by the bench before each fetch.
// Notes: Released answer lines show the inverse of the last value.
`default_nettype none

module dmc_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fetch_req,
  input wire dmc_pkg::dmc_ptr_type ans,
  input wire logic err,
  input wire logic [2:0] dly,
  output logic fetch_ack,
  output dmc_pkg::dmc_ptr_type fetch_ans,
  output logic fetch_err
);
  logic [2:0] cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_ack <= 1'b0;
      cnt <= 3'h0;
      fetch_ans <= '0;
      fetch_err <= 1'b0;
    end else if (fetch_ack) begin
      fetch_ack <= 1'b0;
      cnt <= 3'h0;
      fetch_ans <= ~fetch_ans;
      fetch_err <= ~fetch_err;
    end else if (fetch_req && cnt == dly) begin
      fetch_ack <= 1'b1;
      fetch_ans <= ans;
      fetch_err <= err;
    end else if (fetch_req) begin
      cnt <= cnt + 3'h1;
    end
  end
endmodule : dmc_mem_model

`default_nettype wire

// ### test/tb_top.sv
// Purpose: Self-checking bench for the DMA context control block.
// Assumes: Default parameters, count limit of eight.
// Notes: Random receive traffic from a fixed seed.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, reg_wr, reg_rd, fetch_req, fetch_ack, fetch_err, merr;
  logic fatal_error_event, rx_valid, rx_ready, selfid_phase, resp_space;
  logic req_fifo_full, phys_valid, phys_ready, selfid_wr, resp_wr, req_wr;
  logic ack_busy, link_fail, drain_valid, drain_ready, ctx_ready, req_deliver;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, phys_data, rx_out_data, s = 32'h000019A1;
  logic [3:0] sched_slot, ctx_fault, ctx_done_evt, ctx_halt_evt;
  logic [3:0] halts = 4'h0, dones = 4'h0;
  logic [4:0] fault_code;
  logic [2:0] mdly;
  logic [1:0] fetch_ctx;
  logic sel_en = 1'b1;
  dmc_pkg::dmc_ptr_type fetch_ptr, fetch_ans, mans;
  dmc_pkg::dmc_rx_type rx_pkt;
  int err_total = 0, num_checks = 0, cyc = 0;

  dmc_context_control i_dmc_context_control (.clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sched_slot, .ctx_fault,
    .fault_code, .fetch_req, .fetch_ptr, .fetch_ctx, .fetch_ack, .fetch_ans,
    .fetch_err, .ctx_done_evt, .ctx_halt_evt, .fatal_error_event, .rx_valid,
    .rx_ready, .rx_pkt, .selfid_phase, .resp_space, .req_fifo_full,
    .phys_valid, .phys_ready, .phys_data, .rx_out_data, .selfid_wr, .resp_wr,
    .req_wr, .ack_busy, .link_fail, .drain_valid, .drain_ready, .ctx_ready,
    .req_deliver);
  dmc_mem_model i_dmc_mem_model (.clk, .rst_n, .fetch_req, .ans(mans),
    .err(merr), .dly(mdly), .fetch_ack, .fetch_ans, .fetch_err);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    halts <= halts | ctx_halt_evt;
    dones <= dones | ctx_done_evt;
    sched_slot <= 4'(rnd());
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd
  function automatic logic [7:0] ca(int n, int p = 0);
    return dmc_pkg::REG_CTL_BASE + 8'(n) * dmc_pkg::CTX_STRIDE + 8'(4 * p);
  endfunction : ca
  function automatic logic [31:0] cw(logic g, h, logic [4:0] c);
    cw = {27'h0, c};
    cw[dmc_pkg::CTL_GO_BIT] = g;
    cw[dmc_pkg::CTL_HALTED_BIT] = h;
  endfunction : cw
  function automatic logic [4:0] rx_exp(logic [1:0] k, logic ph, sp, bz);
    case (k)
      2'h0: return 5'h10;
      2'h1: if (ph) return {1'b0, sel_en, 3'h0};
      2'h2: return {2'h0, sp, 2'h0};
      default: ;
    endcase
    return bz ? 5'h01 : 5'h02;
  endfunction : rx_exp
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFFFFFF);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, e);
  endtask : rd
  task automatic fx(input logic [27:0] ea, input logic [31:0] an, input e);
    int n = 0;
    mans <= an;
    merr <= e;
    mdly <= 3'(rnd());
    while (fetch_req !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(fetch_ptr.addr), 32'(ea));
    while (fetch_req === 1'b1 && n < 800) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : fx
  task automatic rxrun(input int n, input logic lf);
    logic [31:0] r, d;
    sel_en = s[9];
    wr(dmc_pkg::REG_RX_CFG, 32'(sel_en));
    rd(dmc_pkg::REG_RX_CFG, 32'(sel_en), 32'h1);
    for (int i = 0; i < n; i++) begin
      r = rnd();
      d = rnd();
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_pkt <= {r[1:0], d};
      selfid_phase <= r[2];
      resp_space <= r[3];
      req_fifo_full <= r[4];
      drain_valid <= r[5];
      ctx_ready <= r[6];
      @(posedge clk);
      rx_valid <= 1'b0;
      #1;
      chk({phys_valid, selfid_wr, resp_wr, req_wr, ack_busy},
          rx_exp(r[1:0], r[2], r[3], r[4] | lf));
      chk(req_deliver, r[5] & ~lf);
      chk(drain_ready, r[6] | lf);
      if (phys_valid === 1'b1) chk(phys_data, d);
      if (req_wr === 1'b1) chk(rx_out_data, d);
    end
    $display("receive batch done");
  endtask : rxrun
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int n;
    logic [4:0] c;
    {rst_n, reg_wr, reg_rd, merr, rx_valid, selfid_phase} = 6'h00;
    {resp_space, req_fifo_full, drain_valid, ctx_ready} = 4'h0;
    {reg_addr, reg_wdata, rx_pkt, mans, mdly} = '0;
    {ctx_fault, fault_code} = '0;
    phys_ready = 1'b1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(ca(0), 32'h0);
    rd(8'h80, 32'h0);
    wr(ca(1), 32'h0C1F);
    rd(ca(1), 32'h0);
    rxrun(24, 1'b0);
    wr(ca(0, 1), {28'h0123456, 4'h2});
    wr(ca(0), cw(1, 0, 0));
    fx(28'h0123456, {28'h0ABCDE0, 4'h3}, 1'b0);
    fx(28'h0ABCDE0, {28'h0777777, 4'h0}, 1'b0);
    fx(28'h0ABCDE0, {28'h0777777, 4'h0}, 1'b0);
    rd(ca(0), cw(1, 0, 0));
    rd(ca(0, 1), {28'h0ABCDE0, 4'h0}, 32'hFFFFFFF0);
    wr(ca(0), cw(1, 0, 0) | 32'h1000);
    fx(28'h0ABCDE0, {28'h0777777, 4'h0}, 1'b0);
    fx(28'h0ABCDE0, {28'h0777777, 4'h0}, 1'b0);
    rd(ca(0), cw(1, 0, 0));
    for (int i = 0; i < 2; i++) begin
      wr(ca(1, 1), i ? 32'h9 : 32'h0);
      wr(ca(1), cw(1, 0, 0));
      rd(ca(1), cw(1, 1, dmc_pkg::EVT_UNKNOWN));
      wr(ca(1), 32'h0);
      rd(ca(1), cw(0, 0, dmc_pkg::EVT_UNKNOWN));
    end
    $display("count test done");
    mans <= {28'h0333330, 4'h5};
    wr(ca(1, 1), {28'h0444440, 4'h4});
    wr(ca(1), cw(1, 0, 0));
    wr(ca(1), 32'h0);
    for (n = 0; n < 500 && dones[1] !== 1'b1; n++) @(posedge clk);
    rd(ca(1), cw(0, 0, dmc_pkg::EVT_UNKNOWN));
    c = 5'(rnd());
    wr(ca(3, 1), {28'h0555550, 4'h8});
    wr(ca(3), cw(1, 0, 0));
    @(posedge clk);
    ctx_fault <= 4'h8;
    fault_code <= c;
    @(posedge clk);
    ctx_fault <= 4'h0;
    rd(ca(3), cw(1, 1, c));
    wait (fetch_req === 1'b0);
    wr(ca(2, 1), {28'h0666660, 4'h1});
    wr(ca(2), cw(1, 0, 0));
    fx(28'h0666660, {28'h0111110, 4'h2}, 1'b1);
    rd(ca(2), cw(1, 1, dmc_pkg::EVT_UNKNOWN));
    rd(ca(2, 1), {28'h0666660, 4'h0}, 32'hFFFFFFF0);
    chk(link_fail, 1'b1);
    rd(dmc_pkg::REG_RX_STAT, 32'h1, 32'h1);
    rxrun(16, 1'b1);
    chk(halts, 4'hE);
    chk(dones, 4'h2);
    $display("context tests done");
    complete_run();
  end
endmodule : tb_top

`default_nettype wire
